// File: include/tca_pkg.sv
/*
 * Constants for the touch controller host access block: timing limits,
 * averaging settings and sleep interval codes.
 * Assumes a 250 MHz core clock.
 */
package tca_pkg;
    localparam int CLK_PERIOD_PS = 4000;
    // acknowledge limits, as printed in microseconds
    localparam int ACK_CRIT_US = 140;
    localparam int ACK_STORE_US = 100;
    // longest times round down to whole cycles
    localparam int ACK_CRIT_CYC = (ACK_CRIT_US * 1000000) / CLK_PERIOD_PS;
    localparam int ACK_STORE_CYC = (ACK_STORE_US * 1000000) / CLK_PERIOD_PS;
    localparam int CNT_W = 16;
    localparam int SAMP_W = 16;
    localparam int ACC_W = 20;
    // averaging depth codes: 2, 4, 8, 16 samples
    localparam logic [1:0] AVG_2 = 2'h0;
    localparam logic [1:0] AVG_4 = 2'h1;
    localparam logic [1:0] AVG_8 = 2'h2;
    localparam logic [1:0] AVG_16 = 2'h3;
    // sleep interval codes
    localparam logic [1:0] SLP_512HZ = 2'h0;
    localparam logic [1:0] SLP_64HZ = 2'h1;
    localparam logic [1:0] SLP_8HZ = 2'h2;
    localparam logic [1:0] SLP_1HZ = 2'h3;
    localparam logic [SAMP_W-1:0] SAMP_RST = 16'h0000;
endpackage

// File: hdl/tca_host_access.sv
/*
 * Host access timing and sample filtering of a touch controller slave.
 * Assumes a byte-level slave front end signals each access needing an
 * acknowledge, and an external store engine reports completion.
 * Scan start, scan done and bus activity come from on-chip logic on
 * the same clock; the open-drain clock pad is outside this block.
 */
`timescale 1ns/100ps

module tca_host_access (
    input wire logic i_clock,
    input wire logic i_rst,
    input wire logic i_boot_done,
    input wire logic i_bus_active,
    input wire logic i_ack_req,
    input wire logic i_ack_is_store,
    input wire logic i_ack_data_ready,
    input wire logic i_store_done,
    input wire logic [1:0] i_sleep_sel,
    input wire logic i_avg_en,
    input wire logic [1:0] i_avg_sel,
    input wire logic i_drop_en,
    input wire logic i_scan_start,
    input wire logic i_scan_done,
    input wire logic [tca_pkg::SAMP_W-1:0] i_scan_count,
    output logic o_scl_out,
    output logic o_scl_oe,
    output logic o_ack_now,
    output logic o_busy,
    output logic o_ack_late,
    output logic o_store_start,
    output logic o_store_bad_sleep,
    output logic o_sample_valid,
    output logic [tca_pkg::SAMP_W-1:0] o_sample
);
    typedef enum logic [1:0] {ST_IDLE, ST_PREP, ST_STORE} tca_state_type;

    tca_state_type state_q, state_d;
    logic [tca_pkg::CNT_W-1:0] cnt_q, cnt_d;
    logic is_store_q, is_store_d;
    logic late_q, late_d;
    logic bad_q, bad_d;
    logic ack_q, ack_d;
    logic start_q, start_d;
    logic [tca_pkg::CNT_W-1:0] limit;

    // limit depends on access kind; the counter is sized for the longer
    // critical deadline, so both limits fit without wrapping
    always_comb begin
        limit = is_store_q ? tca_pkg::CNT_W'(tca_pkg::ACK_STORE_CYC - 1)
                           : tca_pkg::CNT_W'(tca_pkg::ACK_CRIT_CYC - 1);
    end

    // acknowledge sequencing; forced ack at the deadline so latency holds
    // even when the data path is slow
    always_comb begin
        state_d = state_q;
        cnt_d = cnt_q;
        is_store_d = is_store_q;
        late_d = late_q;
        bad_d = bad_q;
        ack_d = 1'b0;
        start_d = 1'b0;
        case (state_q)
            ST_IDLE: begin
                // boot gates acknowledge requests only; early requests are ignored
                if (i_ack_req && i_boot_done) begin
                    state_d = ST_PREP;
                    cnt_d = '0;
                    is_store_d = i_ack_is_store;
                    late_d = 1'b0;
                end
            end
            ST_PREP: begin
                cnt_d = cnt_q + 1'b1;
                if (i_ack_data_ready || cnt_q == limit) begin
                    ack_d = 1'b1;
                    // late marks an acknowledge forced by the deadline
                    late_d = !i_ack_data_ready;
                    if (is_store_q) begin
                        start_d = 1'b1;
                        // flag a save attempted at a failing interval
                        bad_d = (i_sleep_sel == tca_pkg::SLP_512HZ) ||
                                (i_sleep_sel == tca_pkg::SLP_64HZ);
                        state_d = ST_STORE;
                    end else begin
                        state_d = ST_IDLE;
                    end
                end
            end
            ST_STORE: begin
                // stretch all traffic until store finishes
                // a request seen here is dropped, not queued
                if (i_store_done) begin
                    state_d = ST_IDLE;
                end
            end
            default: state_d = ST_IDLE;
        endcase
    end

    // acknowledge state registers
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            state_q <= ST_IDLE;
            cnt_q <= '0;
            is_store_q <= 1'b0;
            late_q <= 1'b0;
            bad_q <= 1'b0;
            ack_q <= 1'b0;
            start_q <= 1'b0;
        end else begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            is_store_q <= is_store_d;
            late_q <= late_d;
            bad_q <= bad_d;
            ack_q <= ack_d;
            start_q <= start_d;
        end
    end

    // scl held low while preparing or storing
    // open drain: the pad only ever pulls low, so the level is fixed
    assign o_scl_out = 1'b0;
    assign o_scl_oe = (state_q != ST_IDLE);
    assign o_busy = (state_q == ST_STORE);
    assign o_ack_now = ack_q;
    assign o_ack_late = late_q;
    assign o_store_start = start_q;
    assign o_store_bad_sleep = bad_q;

    // sample filters
    // the sum register holds sixteen full-scale counts
    logic dirty_q, dirty_d;
    logic [tca_pkg::ACC_W-1:0] acc_q, acc_d;
    logic [4:0] n_q, n_d;
    logic [4:0] n_need;
    logic [tca_pkg::SAMP_W-1:0] samp_q, samp_d;
    logic vld_q, vld_d;

    // samples needed per averaged result
    always_comb begin
        case (i_avg_sel)
            tca_pkg::AVG_2: n_need = 5'h02;
            tca_pkg::AVG_4: n_need = 5'h04;
            tca_pkg::AVG_8: n_need = 5'h08;
            default: n_need = 5'h10;
        endcase
    end

    // traffic mark per scan; averaging across accepted samples only
    always_comb begin
        dirty_d = dirty_q;
        acc_d = acc_q;
        n_d = n_q;
        samp_d = samp_q;
        vld_d = 1'b0;
        // traffic beats a scan start in the same cycle, so a sample
        // never slips past the drop filter on a tie
        if (i_bus_active) begin
            dirty_d = 1'b1;
        end else if (i_scan_start) begin
            dirty_d = 1'b0;
        end
        if (i_scan_done && !(i_drop_en && (dirty_q || i_bus_active))) begin
            // sample survives the drop filter
            if (!i_avg_en) begin
                samp_d = i_scan_count;
                vld_d = 1'b1;
                acc_d = '0;
                n_d = '0;
            end else if (n_q + 5'h01 >= n_need) begin
                // at or past the depth: a depth lowered mid-run still
                // closes the group rather than letting the count wrap
                acc_d = acc_q + tca_pkg::ACC_W'(i_scan_count);
                case (i_avg_sel)
                    tca_pkg::AVG_2: samp_d = acc_d[16:1];
                    tca_pkg::AVG_4: samp_d = acc_d[17:2];
                    tca_pkg::AVG_8: samp_d = acc_d[18:3];
                    default: samp_d = acc_d[19:4];
                endcase
                vld_d = 1'b1;
                acc_d = '0;
                n_d = '0;
            end else begin
                acc_d = acc_q + tca_pkg::ACC_W'(i_scan_count);
                n_d = n_q + 5'h01;
            end
        end
    end

    // filter state registers
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            dirty_q <= 1'b0;
            acc_q <= '0;
            n_q <= '0;
            samp_q <= tca_pkg::SAMP_RST;
            vld_q <= 1'b0;
        end else begin
            dirty_q <= dirty_d;
            acc_q <= acc_d;
            n_q <= n_d;
            samp_q <= samp_d;
            vld_q <= vld_d;
        end
    end

    // sample outputs straight from flip-flops
    assign o_sample = samp_q;
    assign o_sample_valid = vld_q;
endmodule // tca_host_access

// File: verif/tca_access_checker.sv
/* timing and filter checker for tca_host_access
   bound to every instance; one clock, sync reset */
`timescale 1ns/100ps
module tca_access_checker (
    input wire logic i_clock,
    input wire logic i_rst,
    input wire logic i_boot_done,
    input wire logic i_bus_active,
    input wire logic i_ack_req,
    input wire logic i_store_done,
    input wire logic i_avg_en,
    input wire logic i_drop_en,
    input wire logic i_scan_done,
    input wire logic [tca_pkg::SAMP_W-1:0] i_scan_count,
    input wire logic o_scl_oe,
    input wire logic o_ack_now,
    input wire logic o_busy,
    input wire logic o_store_start,
    input wire logic o_sample_valid,
    input wire logic [tca_pkg::SAMP_W-1:0] o_sample
);
    logic [15:0] st_q;
    logic [15:0] st_d;
    // stretch length so far, cleared one cycle after the line frees
    always_comb st_d = o_scl_oe ? st_q + 16'h1 : 16'h0;
    always_ff @(posedge i_clock) st_q <= i_rst ? 16'h0 : st_d;
    default clocking @(posedge i_clock); endclocking
    default disable iff (i_rst);
    sequence s_req;
        i_ack_req && i_boot_done && !o_scl_oe && !o_busy && !o_ack_now;
    endsequence
    a_stretch_start: assert property (s_req |=> o_scl_oe)
        else $error("request not stretched");
    a_crit_bound: assert property (
        o_scl_oe && !o_busy |-> st_q < 16'h88b8)
        else $error("critical ack too late");
    a_store_bound: assert property (
        o_store_start |-> o_ack_now && st_q <= 16'h61a8)
        else $error("store ack too late");
    a_busy_release: assert property (
        o_busy && i_store_done |=> !o_busy && !o_scl_oe)
        else $error("busy not released");
    a_pass_through: assert property (
        i_scan_done && !i_avg_en && !i_drop_en
        |=> o_sample_valid && o_sample == $past(i_scan_count))
        else $error("raw sample not passed");
    a_drop_sample: assert property (
        i_drop_en && i_scan_done && i_bus_active |=> !o_sample_valid)
        else $error("disturbed sample kept");
endmodule // tca_access_checker
bind tca_host_access tca_access_checker u_chk (.*);

// File: verif/tca_host_model.sv
/* host master model issuing accesses one at a time
   called from tb_top; acknowledge seen on the clock edge */
`timescale 1ns/100ps
module tca_host_model (
    input wire logic i_clock,
    input wire logic i_boot_done,
    input wire logic i_scl_oe,
    input wire logic i_ack,
    input wire logic [1:0] i_sleep,
    output logic o_req,
    output logic o_store,
    output logic o_bus
);
    initial {o_req, o_store, o_bus} = 3'h0;
    // n returns cycles from request to acknowledge
    task automatic xfer(input logic st, output int n);
        n = -1;
        @(posedge i_clock);
        while (!i_boot_done || i_scl_oe) @(posedge i_clock);
        if (st && i_sleep < tca_pkg::SLP_8HZ) return;
        o_req <= 1'b1;
        o_store <= st;
        o_bus <= 1'b1;
        @(posedge i_clock) o_req <= 1'b0;
        for (n = 0; n < 40000 && !i_ack; n++) @(posedge i_clock);
        o_bus <= 1'b0;
        o_store <= 1'b0;
    endtask
endmodule // tca_host_model

// File: verif/tb_top.sv
/* self-checking bench for tca_host_access
   host model makes accesses, bench drives scans and store */
`timescale 1ns/100ps
`define CHK(nm, e, a) begin comparisons++; if ((a) !== (e)) begin \
    n_errors++; $display("MISMATCH %s exp %0h got %0h", nm, e, a); end end
module tb_top;
    logic i_clock = 0, i_rst = 1, boot = 0, dr = 0, sd = 0, ss = 0;
    logic sdn = 0, tr = 0, ae = 0, de = 0;
    logic [1:0] slp = 2'h0, as = 2'h0;
    logic [15:0] cnt = 16'h0, smp;
    logic req, sto, bus, oe, ack, busy, late, bad, sv, so, stt;
    int n_errors = 0, comparisons = 0, cyc = 0, n, i, k, n_start = 0;
    always #2 i_clock = ~i_clock;
    tca_host_access uut (.i_clock(i_clock), .i_rst(i_rst),
        .i_boot_done(boot), .i_bus_active(bus | tr), .i_ack_req(req),
        .i_ack_is_store(sto), .i_ack_data_ready(dr), .i_store_done(sd),
        .i_sleep_sel(slp), .i_avg_en(ae), .i_avg_sel(as), .i_drop_en(de),
        .i_scan_start(ss), .i_scan_done(sdn), .i_scan_count(cnt),
        .o_scl_out(so), .o_scl_oe(oe), .o_ack_now(ack), .o_busy(busy),
        .o_ack_late(late), .o_store_start(stt), .o_store_bad_sleep(bad),
        .o_sample_valid(sv), .o_sample(smp));
    tca_host_model host (.i_clock(i_clock), .i_boot_done(boot),
        .i_scl_oe(oe), .i_ack(ack), .i_sleep(slp), .o_req(req),
        .o_store(sto), .o_bus(bus));
    // one scan, optional traffic while it runs
    task automatic scan(input logic [15:0] v, input logic t);
        @(posedge i_clock) ss <= 1'b1;
        @(posedge i_clock) {ss, sdn, cnt, tr} <= {2'h1, v, t};
        @(posedge i_clock) {sdn, tr} <= 2'h0;
        #1;
    endtask
    task automatic test_done;
        $display("errors %0d comparisons %0d", n_errors, comparisons);
        if (n_errors == 0 && comparisons > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    // hang guard, runs well past the two forced deadlines
    always @(posedge i_clock) begin
        cyc++;
        if (cyc == 70000) begin
            n_errors++;
            test_done();
        end
    end
    // store starts seen at clock edges
    always @(posedge i_clock) if (stt === 1'b1) n_start++;
    initial begin
        repeat (20) @(posedge i_clock);
        i_rst <= 1'b0;
        @(posedge i_clock) {boot, dr} <= 2'h3;
        `CHK("scl", 1'b0, so)
        host.xfer(1'b0, n);
        `CHK("fast", 2, n)
        dr <= 1'b0;
        fork
            host.xfer(1'b0, n);
            begin repeat (100) @(posedge i_clock); dr <= 1'b1; end
        join
        `CHK("slow", 1'b1, n > 95 && n < 106)
        `CHK("ontime", 1'b0, late)
        dr <= 1'b0;
        host.xfer(1'b0, n);
        `CHK("crit", 1'b1, n > 34990 && n < 35002)
        `CHK("forced", 1'b1, late)
        slp <= tca_pkg::SLP_8HZ; // slow sleep before saving
        host.xfer(1'b1, n);
        `CHK("store", 1'b1, n > 24990 && n < 25002)
        `CHK("busy", 1'b1, busy)
        `CHK("sleep", 1'b0, bad)
        `CHK("hold", 1'b1, oe)
        @(posedge i_clock) sd <= 1'b1;
        @(posedge i_clock) {sd, dr, slp} <= {2'h1, tca_pkg::SLP_512HZ};
        #1 `CHK("free", 1'b0, busy)
        `CHK("starts", 1, n_start)
        host.xfer(1'b1, n); // save at 512 Hz must not go out
        `CHK("refused", -1, n)
        @(posedge i_clock) ae <= 1'b1; // enabled only after power-up
        for (k = 0; k < 4; k++) begin
            @(posedge i_clock) as <= k[1:0];
            for (i = 0; i < (2 << k); i++) scan(16'(i * 16), 1'b0);
            `CHK("avg", 16'((2 << k) * 8 - 8), smp)
            `CHK("avgv", 1'b1, sv)
        end
        @(posedge i_clock) ae <= 1'b0;
        scan(16'h4321, 1'b0);
        `CHK("raw", 16'h4321, smp)
        @(posedge i_clock) de <= 1'b1;
        scan(16'h1234, 1'b1);
        `CHK("drop", 1'b0, sv)
        `CHK("held", 16'h4321, smp)
        // traffic only in the middle of the scan
        @(posedge i_clock) ss <= 1'b1;
        @(posedge i_clock) {ss, tr} <= 2'h1;
        @(posedge i_clock) {sdn, cnt, tr} <= {1'b1, 16'h5678, 1'b0};
        @(posedge i_clock) sdn <= 1'b0;
        #1 `CHK("mid", 1'b0, sv)
        scan(16'h2468, 1'b0);
        `CHK("kept", 16'h2468, smp)
        `CHK("keptv", 1'b1, sv)
        test_done();
    end
endmodule // tb_top
